// *** design/cam_video_port.sv ***
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// R1 - timing input: trigger or integration window
// R2 - timing input resampled on line clock
// R3 - frame valid high on frame lines
// R4 - line valid high on active pixels
// R5 - data valid high on valid samples
// R6 - pixel value is 12-bit parallel word
// R7 - shutter high while open, delayed readout
// R8 - colour select chooses next frame colour
// R9 - colour identity outputs report current frame
// R10 - colour identity in word bits 13:12
// R11 - control lines arrive on camera-control pairs
// R12 - connector copies combined by AND
// R13 - unconnected control inputs read high
// R14 - shutter, colour outputs duplicated per connector
// R15 - receiver takes pixels when both valids high; the grabber model also needs data valid high
// R16 - 25 MHz pixel clock, binning lowers rate
// R17 - rising trigger starts integration
// R18 - window falling starts, rising stops integration
// R19 - colour sampled once per frame
// R20 - video changes only on pixel clock fall
module cam_video_port
    import cam_port_pkg::*;
#(
    parameter int ACT_PIXELS = cam_port_pkg::ACTIVE_PIXELS,
    parameter int ACT_LINES  = cam_port_pkg::ACTIVE_LINES,
    parameter int MS_COUNT   = cam_port_pkg::MS_CYCLES
) (
    input  wire logic                             SYS_CLK,
    input  wire logic                             RESETN,
    input  wire logic [cam_port_pkg::ADDR_W-1:0]  AWADDR,
    input  wire logic                             AWVALID,
    output logic                                  AWREADY,
    input  wire logic [31:0]                      WDATA,
    input  wire logic [3:0]                       WSTRB,
    input  wire logic                             WVALID,
    output logic                                  WREADY,
    output logic      [1:0]                       BRESP,
    output logic                                  BVALID,
    input  wire logic                             BREADY,
    input  wire logic [cam_port_pkg::ADDR_W-1:0]  ARADDR,
    input  wire logic                             ARVALID,
    output logic                                  ARREADY,
    output logic      [31:0]                      RDATA,
    output logic      [1:0]                       RRESP,
    output logic                                  RVALID,
    input  wire logic                             RREADY,
    input  wire logic                             TIMING_CONTROL_IN_DIFF,
    input  wire logic                             TIMING_CONTROL_IN_TTL,
    input  wire logic [1:0]                       COLOUR_SELECT_IN_DIFF,
    input  wire logic [1:0]                       COLOUR_SELECT_IN_TTL,
    output logic                                  PIXEL_CLK,
    output logic      [13:0]                      PIXEL_WORD,
    output logic                                  FRAME_VALID,
    output logic                                  LINE_VALID,
    output logic                                  DATA_VALID,
    output logic                                  FRAME_VALID_N,
    output logic                                  LINE_VALID_N,
    output logic                                  SHUTTER_DIFF,
    output logic                                  SHUTTER_TTL,
    output logic      [1:0]                       COLOUR_IDENTITY_OUT_DIFF,
    output logic      [1:0]                       COLOUR_IDENTITY_OUT_TTL
);
    import cam_port_pkg::*;

    localparam int          MS_W     = (MS_COUNT > 1) ? $clog2(MS_COUNT) : 1;
    localparam logic [11:0] LINE_SPAN = 12'(ACT_PIXELS + BLANK_SLOTS);
    localparam logic [11:0] ACT_PIX  = 12'(ACT_PIXELS);
    localparam logic [11:0] ACT_LIN  = 12'(ACT_LINES);
    localparam logic [MS_W-1:0] MS_LAST  = MS_W'(MS_COUNT - 1);
    localparam logic [1:0]  PDIV_LAST = 2'(PIX_HALF - 1);

    typedef struct packed {
        cam_state_t  st;
        logic [1:0]  pdiv;
        logic        pclk;
        logic [11:0] col;
        logic [11:0] row;
        logic [15:0] lcnt;
        logic [MS_W-1:0] mscnt;
        logic [5:0]  dcnt;
        logic        tc_line;
        logic [1:0]  colour;
        logic [13:0] word;
        logic        lval;
        logic        fval;
        logic        dval;
        logic        fval_n;
        logic        lval_n;
        logic        shutter;
        logic [15:0] fcount;
        logic [31:0] ctrl;
        logic [15:0] integ;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        aw_have;
        logic        w_have;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } port_state_t;

    localparam port_state_t S_RESET = '{
        st: ST_WAIT, pdiv: 2'h0, pclk: 1'b0, col: 12'h000, row: 12'h000, lcnt: 16'h0000,
        mscnt: '0, dcnt: 6'h00, tc_line: 1'b1, colour: 2'h0, word: 14'h0000, lval: 1'b0,
        fval: 1'b0, dval: 1'b0, fval_n: 1'b1, lval_n: 1'b1, shutter: 1'b0, fcount: 16'h0000, ctrl: CTRL_RESET,
        integ: INTEG_RESET, awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: RESP_OKAY,
        aw_have: 1'b0, w_have: 1'b0, awaddr: 8'h00, wdata: 32'h0000_0000, wstrb: 4'h0,
        arready: 1'b1, rvalid: 1'b0, rresp: RESP_OKAY, rdata: 32'h0000_0000};

    port_state_t s;
    port_state_t next_s;
    logic [2:0]  ctl_in;
    logic        tc_eff;
    logic [1:0]  sel_eff;
    tmode_t      mode;
    logic [1:0]  bin;
    logic [11:0] bin_mask;
    logic [11:0] edge_lines;
    logic [11:0] last_row;
    logic [5:0]  dly_target;
    logic        slot;
    logic        line_tick;
    logic        ms_tick;
    logic        rise_ev;
    logic        fall_ev;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================
    // Control inputs
    // R11 camera-control pair copies
    cam_input_and #(.W(3)) u_ctl_in (
        .clk    (SYS_CLK),
        .rst_n  (RESETN),
        .copy_a ({COLOUR_SELECT_IN_DIFF, TIMING_CONTROL_IN_DIFF}),
        .copy_b ({COLOUR_SELECT_IN_TTL, TIMING_CONTROL_IN_TTL}),
        .merged (ctl_in)
    );
    assign tc_eff  = ctl_in[0];
    assign sel_eff = ctl_in[2:1];

    // ==========================================
    // Decoded configuration and timing events
    always_comb begin
        mode       = tmode_t'(s.ctrl[CTRL_MODE_LSB +: 2]);
        bin        = (s.ctrl[CTRL_BIN_LSB +: 2] > BIN_4X4) ? BIN_4X4 : s.ctrl[CTRL_BIN_LSB +: 2];
        bin_mask   = ~(12'hFFF << bin);
        edge_lines = (bin == BIN_4X4) ? EDGE_LINES_4X4 : EDGE_LINES;
        last_row   = (edge_lines << 1) + (ACT_LIN >> bin) - 12'h001;
        case (s.ctrl[CTRL_SHUT_LSB +: 2])
            2'h0:    dly_target = SHUT_MS_0;
            2'h1:    dly_target = SHUT_MS_1;
            2'h2:    dly_target = SHUT_MS_2;
            default: dly_target = SHUT_MS_3;
        endcase
        // R20 data moves on pixel clock fall
        slot      = (s.pdiv == PDIV_LAST) && s.pclk;
        line_tick = slot && (s.col == LINE_SPAN - 12'h001);
        ms_tick   = (s.mscnt == MS_LAST);
        // R2 edges seen on line clock
        rise_ev   = line_tick && tc_eff && !s.tc_line;
        fall_ev   = line_tick && !tc_eff && s.tc_line;
    end

    // ==========================================
    // Next state
    always_comb begin
        next_s = s;
        // AXI write: address and data in either order
        if (AWVALID && s.awready) begin
            next_s.aw_have = 1'b1;
            next_s.awaddr  = AWADDR;
            next_s.awready = 1'b0;
        end
        if (WVALID && s.wready) begin
            next_s.w_have = 1'b1;
            next_s.wdata  = WDATA;
            next_s.wstrb  = WSTRB;
            next_s.wready = 1'b0;
        end
        if (next_s.aw_have && next_s.w_have && !s.bvalid) begin
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RESP_OKAY;
            next_s.aw_have = 1'b0;
            next_s.w_have  = 1'b0;
            case (next_s.awaddr)
                REG_CTRL:   next_s.ctrl = merge(s.ctrl, next_s.wdata, next_s.wstrb);
                REG_INTEG:  next_s.integ = 16'(merge({16'h0000, s.integ}, next_s.wdata, next_s.wstrb));
                REG_STATUS: next_s.bresp = RESP_OKAY;
                REG_FCOUNT: next_s.bresp = RESP_OKAY;
                default:    next_s.bresp = RESP_SLVERR;
            endcase
        end
        if (s.bvalid && BREADY) begin
            next_s.bvalid  = 1'b0;
            next_s.awready = 1'b1;
            next_s.wready  = 1'b1;
        end
        // AXI read
        if (ARVALID && s.arready) begin
            next_s.arready = 1'b0;
            next_s.rvalid  = 1'b1;
            next_s.rresp   = RESP_OKAY;
            case (ARADDR)
                REG_CTRL:   next_s.rdata = s.ctrl;
                REG_INTEG:  next_s.rdata = {16'h0000, s.integ};
                REG_STATUS: next_s.rdata = {24'h000000, s.fval, tc_eff, s.colour, s.st};
                REG_FCOUNT: next_s.rdata = {16'h0000, s.fcount};
                default: begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (s.rvalid && RREADY) begin
            next_s.rvalid  = 1'b0;
            next_s.arready = 1'b1;
        end

        // R16 fixed 25 MHz pixel clock
        if (s.pdiv == PDIV_LAST) begin
            next_s.pdiv = 2'h0;
            next_s.pclk = !s.pclk;
        end else begin
            next_s.pdiv = s.pdiv + 2'h1;
        end
        if (slot) begin
            next_s.col = line_tick ? 12'h000 : s.col + 12'h001;
        end
        if (line_tick) begin
            next_s.tc_line = tc_eff;
        end
        next_s.mscnt = ms_tick ? '0 : s.mscnt + MS_W'(1);

        case (s.st)
            ST_WAIT: begin
                // R1 R17 R18 start by timing mode
                if (line_tick && ((mode == MODE_FREE) || (mode == MODE_TRIG && rise_ev) ||
                                  (mode == MODE_WIN && fall_ev))) begin
                    next_s.st   = ST_INTEG;
                    next_s.lcnt = 16'h0000;
                    // R8 R19 colour taken once per frame
                    next_s.colour = s.ctrl[CTRL_COLOUR_BIT] ? sel_eff : 2'h0;
                end
            end
            ST_INTEG: begin
                if (mode == MODE_WIN) begin
                    // R18 window rise ends integration
                    if (rise_ev) begin
                        next_s.st = ST_SHUT;
                    end
                end else if (line_tick) begin
                    next_s.lcnt = s.lcnt + 16'h0001;
                    if (next_s.lcnt >= s.integ) begin
                        next_s.st = ST_SHUT;
                    end
                end
                next_s.dcnt  = 6'h00;
                next_s.mscnt = '0;
            end
            ST_SHUT: begin
                // R7 readout after chosen delay
                if (ms_tick && s.dcnt != dly_target) begin
                    next_s.dcnt = s.dcnt + 6'h01;
                end
                if (s.dcnt == dly_target && line_tick) begin
                    next_s.st  = ST_READ;
                    next_s.row = 12'h000;
                end
            end
            ST_READ: begin
                if (line_tick) begin
                    if (s.row == last_row) begin
                        next_s.st     = ST_WAIT;
                        next_s.fcount = s.fcount + 16'h0001;
                    end else begin
                        next_s.row = s.row + 12'h001;
                    end
                end
            end
            default: next_s.st = ST_WAIT;
        endcase

        if (slot) begin
            // R4 active pixels of a line
            next_s.lval = (next_s.st == ST_READ) && (next_s.col < ACT_PIX);
            // R3 lines inside the frame
            next_s.fval = (next_s.st == ST_READ) && (next_s.row >= edge_lines) &&
                          (next_s.row < edge_lines + (ACT_LIN >> bin));
            // R5 R16 one valid sample per binned pixel
            next_s.dval = ((next_s.col & bin_mask) == 12'h000);
            // R6 twelve-bit ramp as pixel value
            next_s.word[11:0] = next_s.lval ? (next_s.col >> bin) : 12'h000;
            next_s.fval_n     = !next_s.fval;
            next_s.lval_n     = !next_s.lval;
        end
        // R9 R10 colour identity in word and pins
        next_s.word[13:12] = next_s.colour;
        // R7 shutter open during integration
        next_s.shutter = (next_s.st == ST_INTEG);
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            s <= S_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================
    // Outputs
    assign AWREADY    = s.awready;
    assign WREADY     = s.wready;
    assign BVALID     = s.bvalid;
    assign BRESP      = s.bresp;
    assign ARREADY    = s.arready;
    assign RVALID     = s.rvalid;
    assign RRESP      = s.rresp;
    assign RDATA      = s.rdata;
    assign PIXEL_CLK  = s.pclk;
    assign PIXEL_WORD = s.word;
    assign FRAME_VALID   = s.fval;
    assign LINE_VALID    = s.lval;
    assign DATA_VALID    = s.dval;
    assign FRAME_VALID_N = s.fval_n;
    assign LINE_VALID_N  = s.lval_n;
    // R14 same flops feed both connectors
    assign SHUTTER_DIFF  = s.shutter;
    assign SHUTTER_TTL   = s.shutter;
    assign COLOUR_IDENTITY_OUT_DIFF = s.colour;
    assign COLOUR_IDENTITY_OUT_TTL  = s.colour;

    // ==========================================
    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    a_fval_in_read: assert property (FRAME_VALID |-> s.st == ST_READ && LINE_VALID_N == !LINE_VALID) // R3
        else $error("frame valid outside readout");
    a_lval_active_col: assert property (LINE_VALID |-> s.col < ACT_PIX && s.st == ST_READ) // R4
        else $error("line valid outside active pixels");
    a_dval_full_rate: assert property (slot && bin == BIN_1X1 |=> DATA_VALID) // R5
        else $error("data valid low at full rate");
    a_word_on_fall: assert property ($changed(PIXEL_WORD) |-> !PIXEL_CLK && $past(PIXEL_CLK)) // R20
        else $error("video word changed off the pixel clock fall");
    a_shutter_state: assert property (SHUTTER_DIFF == (s.st == ST_INTEG)) // R7
        else $error("shutter does not match integration");
    a_read_after_dly: assert property ($rose(s.st == ST_READ) |-> $past(s.dcnt) == $past(dly_target)) // R7
        else $error("readout started before shutter delay");
    a_copies_equal: assert property (SHUTTER_DIFF == SHUTTER_TTL && // R14
        COLOUR_IDENTITY_OUT_DIFF == COLOUR_IDENTITY_OUT_TTL)
        else $error("connector copies differ");
    a_id_in_word: assert property (PIXEL_WORD[13:12] == COLOUR_IDENTITY_OUT_DIFF) // R10
        else $error("colour bits of word differ from identity");
    a_colour_hold: assert property (s.st != ST_WAIT && $past(s.st) != ST_WAIT |-> $stable(s.colour)) // R19
        else $error("colour identity changed inside a frame");
    a_start_on_line: assert property ($rose(s.st == ST_INTEG) |-> $past(line_tick)) // R2
        else $error("integration start not on line clock");
    a_trig_start: assert property (s.st == ST_WAIT && mode == MODE_TRIG && rise_ev |=> s.st == ST_INTEG) // R17
        else $error("trigger rise did not start integration");
    a_window_stop: assert property (s.st == ST_INTEG && mode == MODE_WIN && rise_ev |=> s.st == ST_SHUT) // R18
        else $error("window rise did not stop integration");

    c_frame_done: cover property (s.st == ST_READ ##1 s.st == ST_WAIT);
    c_trig_frame: cover property (mode == MODE_TRIG && $rose(s.st == ST_INTEG));
    c_window_frame: cover property (mode == MODE_WIN && $rose(s.st == ST_SHUT));
    c_blue_frame: cover property (FRAME_VALID && COLOUR_IDENTITY_OUT_DIFF == 2'h2);
endmodule

// *** pkg/cam_port_pkg.sv ***
package cam_port_pkg;
    // Clock and timing figures
    localparam int CLK_PERIOD_NSEC    = 10;
    localparam int PIXCLK_PERIOD_NSEC = 40;
    localparam int PIX_HALF           = PIXCLK_PERIOD_NSEC / CLK_PERIOD_NSEC / 2;
    localparam int MS_NSEC            = 1000000;
    localparam int MS_CYCLES          = MS_NSEC / CLK_PERIOD_NSEC;
    localparam int LINE_BLANK_NSEC    = 10000;
    localparam int BLANK_SLOTS        = (LINE_BLANK_NSEC + PIXCLK_PERIOD_NSEC - 1) / PIXCLK_PERIOD_NSEC;
    localparam int ACTIVE_PIXELS    = 2300;
    localparam int ACTIVE_LINES     = 3500;
    localparam logic [11:0] EDGE_LINES     = 12'h004;
    localparam logic [11:0] EDGE_LINES_4X4 = 12'h001;
    // Shutter-to-readout delays in milliseconds
    localparam logic [5:0] SHUT_MS_0 = 6'h01;
    localparam logic [5:0] SHUT_MS_1 = 6'h0A;
    localparam logic [5:0] SHUT_MS_2 = 6'h14;
    localparam logic [5:0] SHUT_MS_3 = 6'h28;
    // Register map
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  REG_CTRL   = 8'h00;
    localparam logic [7:0]  REG_INTEG  = 8'h04;
    localparam logic [7:0]  REG_STATUS = 8'h08;
    localparam logic [7:0]  REG_FCOUNT = 8'h0C;
    localparam int          CTRL_MODE_LSB   = 0;
    localparam int          CTRL_BIN_LSB    = 2;
    localparam int          CTRL_COLOUR_BIT = 4;
    localparam int          CTRL_SHUT_LSB   = 5;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [15:0] INTEG_RESET     = 16'h000A;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    localparam logic [1:0]  BIN_1X1         = 2'h0;
    localparam logic [1:0]  BIN_4X4         = 2'h2;

    typedef enum logic [1:0] {
        MODE_FREE = 2'h0,
        MODE_TRIG = 2'h1,
        MODE_WIN  = 2'h2
    } tmode_t;

    typedef enum logic [3:0] {
        ST_WAIT  = 4'h1,
        ST_INTEG = 4'h2,
        ST_SHUT  = 4'h4,
        ST_READ  = 4'h8
    } cam_state_t;
endpackage

// *** design/cam_input_and.sv ***
`timescale 1ns/10ps
module cam_input_and #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] copy_a,
    input  wire logic [W-1:0] copy_b,
    output logic      [W-1:0] merged
);
    typedef struct packed {
        logic [W-1:0] a1;
        logic [W-1:0] a2;
        logic [W-1:0] b1;
        logic [W-1:0] b2;
        logic [W-1:0] y;
    } sync_t;

    sync_t s;
    sync_t next_s;

    always_comb begin
        next_s    = s;
        next_s.a1 = copy_a;
        next_s.a2 = s.a1;
        next_s.b1 = copy_b;
        next_s.b2 = s.b1;
        // R12 two copies ANDed
        next_s.y  = s.a2 & s.b2;
    end

    // R13 idle inputs read high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign merged = s.y;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_and_merge: assert property (merged == $past(s.a2 & s.b2)) // R12
        else $error("merged input is not the AND of both copies");
endmodule

// *** bench/cam_grabber_model.sv ***
`timescale 1ns/10ps
// ==========================================
// Frame grabber: counts accepted pixels and lines of one frame
module cam_grabber_model (
    input  wire logic        pixel_clk,
    input  wire logic        frame_valid,
    input  wire logic        line_valid,
    input  wire logic        data_valid,
    input  wire logic [13:0] pixel_word,
    output int               samples,
    output int               lines,
    output logic      [1:0]  colour
);
    logic prev_fv;
    logic prev_lv;
    initial begin
        samples = 0;
        lines = 0;
        colour = 2'h0;
        prev_fv = 1'b0;
        prev_lv = 1'b0;
    end
    always @(posedge pixel_clk) begin
        // pixel taken only with frame, line and data valid all high
        if (frame_valid && line_valid && data_valid) begin
            samples <= (prev_fv ? samples : 0) + 1;
            colour <= pixel_word[13:12];
        end else if (frame_valid && !prev_fv) begin
            samples <= 0;
        end
        if (frame_valid && !prev_fv) begin
            lines <= 0;
        end else if (prev_lv && !line_valid && (frame_valid || prev_fv)) begin
            lines <= lines + 1;
        end
        prev_fv <= frame_valid;
        prev_lv <= line_valid;
    end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/10ps
module tb;
    import cam_port_pkg::*;
    localparam int MS_C    = 200;
    localparam int ACT_PIX = 8;
    localparam int ACT_LN  = 4;
    localparam int LINE    = (ACT_PIX + 250) * 2 * PIX_HALF;
    logic        SYS_CLK, RESETN, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY;
    logic        RVALID, RREADY, TIMING_CONTROL_IN_DIFF, TIMING_CONTROL_IN_TTL, PIXEL_CLK, FRAME_VALID;
    logic        LINE_VALID, DATA_VALID, FRAME_VALID_N, LINE_VALID_N, SHUTTER_DIFF, SHUTTER_TTL;
    logic [7:0]  AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, d, f0;
    logic [3:0]  WSTRB;
    logic [1:0]  BRESP, RRESP, r, COLOUR_SELECT_IN_DIFF, COLOUR_SELECT_IN_TTL, seen_colour;
    logic [1:0]  COLOUR_IDENTITY_OUT_DIFF, COLOUR_IDENTITY_OUT_TTL;
    logic [13:0] PIXEL_WORD;
    int          bad_count, n_compared, cyc, samples, lines;

    cam_video_port #(.ACT_PIXELS(ACT_PIX), .ACT_LINES(ACT_LN), .MS_COUNT(MS_C)) uut (.*);
    cam_grabber_model grabber (.pixel_clk(PIXEL_CLK), .frame_valid(FRAME_VALID), .line_valid(LINE_VALID),
        .data_valid(DATA_VALID), .pixel_word(PIXEL_WORD), .samples(samples), .lines(lines), .colour(seen_colour));

    always #(CLK_PERIOD_NSEC / 2) SYS_CLK = ~SYS_CLK;

    // ==========================================
    // Report and compare
    task give_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_rng(input int v, input int lo, input int hi);
        n_compared++;
        if (v < lo || v > hi) begin
            bad_count++;
            $display("[FAIL] t=%0t count %0d outside %0d..%0d", $time, v, lo, hi);
        end
    endtask
    task hang(input int n, input int lim);
        if (n >= lim) begin
            bad_count++;
            $display("[FAIL] t=%0t wait ran out", $time);
            give_verdict();
        end
    endtask

    // ==========================================
    // AXI4-Lite master
    task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        int n;
        AWADDR <= a; AWVALID <= 1'b1; WDATA <= v; WSTRB <= 4'hF; WVALID <= 1'b1; BREADY <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge SYS_CLK);
            if (AWREADY === 1'b1) AWVALID <= 1'b0;
            if (WREADY === 1'b1) WVALID <= 1'b0;
            if (BVALID === 1'b1) break;
        end
        hang(n, 50);
        resp = BRESP;
        BREADY <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        int n;
        ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge SYS_CLK);
            if (ARREADY === 1'b1) ARVALID <= 1'b0;
            if (RVALID === 1'b1) break;
        end
        hang(n, 50);
        v = RDATA;
        resp = RRESP;
        RREADY <= 1'b0;
        @(posedge SYS_CLK);
    endtask

    // ==========================================
    // Waits on video side
    task wait_lvl(input logic fv, input logic lvl, input int lim);
        for (cyc = 0; cyc < lim; cyc++) begin
            @(posedge SYS_CLK);
            if ((fv ? FRAME_VALID : SHUTTER_DIFF) === lvl) break;
        end
        n_compared++;
        hang(cyc, lim);
    endtask
    task wait_idle();
        int n;
        for (n = 0; n < 12000; n++) begin
            rd(REG_STATUS, d, r);
            if (d[3:0] === 4'h1) break;
        end
        hang(n, 12000);
    endtask

    initial begin
        SYS_CLK = 0; RESETN = 0; AWVALID = 0; WVALID = 0; BREADY = 0; ARVALID = 0; RREADY = 0;
        AWADDR = 0; ARADDR = 0; WDATA = 0; WSTRB = 0; bad_count = 0; n_compared = 0;
        TIMING_CONTROL_IN_DIFF = 1; TIMING_CONTROL_IN_TTL = 1;
        COLOUR_SELECT_IN_DIFF = 2'h3; COLOUR_SELECT_IN_TTL = 2'h3;
        repeat (2) @(posedge SYS_CLK);
        RESETN <= 1'b1;
        @(posedge SYS_CLK);
        // ==========================================
        // Registers: reset values, read-only and unmapped places
        rd(REG_CTRL, d, r); chk(d, CTRL_RESET);
        rd(REG_INTEG, d, r); chk(d, {16'h0000, INTEG_RESET});
        rd(REG_STATUS, d, r); chk(d, 32'h0000_0041);
        wr(REG_STATUS, 32'h0000_00FF, r); chk(r, RESP_OKAY);
        rd(REG_STATUS, d, r); chk(d, 32'h0000_0041);
        wr(8'h10, 32'h0000_0001, r); chk(r, RESP_SLVERR);
        rd(8'h10, d, r); chk(d, 32'h0); chk(r, RESP_SLVERR);
        wr(REG_INTEG, 32'h0000_0001, r);
        wr(REG_CTRL, 32'h0000_0071, r);
        rd(REG_CTRL, d, r); chk(d, 32'h0000_0071);
        $display("test registers done");
        // ==========================================
        // Trigger frame, 40 ms shutter delay, blue from ANDed copies
        COLOUR_SELECT_IN_DIFF <= 2'h2;
        wait_idle();
        rd(REG_FCOUNT, f0, r);
        TIMING_CONTROL_IN_DIFF <= 1'b0;
        repeat (LINE + 10) @(posedge SYS_CLK);
        TIMING_CONTROL_IN_DIFF <= 1'b1;
        wait_lvl(1'b0, 1'b1, 2 * LINE + 20);
        chk(SHUTTER_TTL, 1'b1);
        wait_lvl(1'b0, 1'b0, 3 * LINE);
        wait_lvl(1'b1, 1'b1, 60 * LINE);
        chk_rng(cyc, 40 * MS_C + 4 * LINE, 40 * MS_C + 6 * LINE);
        chk(COLOUR_IDENTITY_OUT_DIFF, 2'h2);
        chk(COLOUR_IDENTITY_OUT_TTL, 2'h2);
        chk(PIXEL_WORD[13:12], 2'h2);
        chk(FRAME_VALID_N, 1'b0);
        chk(LINE_VALID_N, 1'b0);
        COLOUR_SELECT_IN_DIFF <= 2'h0;
        wait_lvl(1'b1, 1'b0, 20 * LINE);
        chk(samples, ACT_PIX * ACT_LN);
        chk(lines, ACT_LN);
        chk(seen_colour, 2'h2);
        wait_idle();
        rd(REG_FCOUNT, d, r); chk(d, f0 + 32'h1);
        $display("test trigger frame done");
        // ==========================================
        // Window frame at 4x4 binning, 1 ms delay, green
        COLOUR_SELECT_IN_DIFF <= 2'h3;
        COLOUR_SELECT_IN_TTL <= 2'h1;
        wr(REG_CTRL, 32'h0000_001A, r);
        wait_idle();
        TIMING_CONTROL_IN_DIFF <= 1'b0;
        wait_lvl(1'b0, 1'b1, 2 * LINE + 20);
        repeat (3 * LINE) @(posedge SYS_CLK);
        chk(SHUTTER_DIFF, 1'b1);
        TIMING_CONTROL_IN_DIFF <= 1'b1;
        wait_lvl(1'b0, 1'b0, 2 * LINE + 20);
        wait_lvl(1'b1, 1'b1, 10 * LINE);
        chk_rng(cyc, MS_C + LINE, MS_C + 3 * LINE);
        wait_lvl(1'b1, 1'b0, 10 * LINE);
        chk(samples, ACT_PIX / 4);
        chk(lines, ACT_LN / 4);
        chk(seen_colour, 2'h1);
        wait_idle();
        rd(REG_FCOUNT, d, r); chk(d, f0 + 32'h2);
        $display("test window frame done");
        give_verdict();
    end
endmodule
